// file: core/spc_pkg.sv
// spc_pkg: register map, field positions, reset values and rate divisors
// for the first serial port's control block.
// assumes: the cpu special-function bus uses byte addresses as offsets.
`default_nettype none
package spc_pkg;
  localparam logic [7:0] ADDR_PCON  = 8'h87;
  localparam logic [7:0] ADDR_CON   = 8'h98;
  localparam logic [7:0] ADDR_BUF   = 8'h99;
  localparam logic [7:0] ADDR_CFG   = 8'h9c;
  localparam logic [7:0] ADDR_SLV   = 8'ha9;
  localparam logic [7:0] ADDR_MASK  = 8'hb9;

  localparam logic [7:0] RST_PCON = 8'h00;
  localparam logic [7:0] RST_CON  = 8'h00;
  localparam logic [7:0] RST_CFG  = 8'h08;
  localparam logic [7:0] RST_ADDR = 8'h00;

  // serial_control fields
  localparam int CON_SM0  = 7;
  localparam int CON_SM1  = 6;
  localparam int CON_SM2  = 5;
  localparam int CON_REN  = 4;
  localparam int CON_TB8  = 3;
  localparam int CON_RB8  = 2;
  localparam int CON_TI   = 1;
  localparam int CON_RI   = 0;
  // power_and_baud_control fields
  localparam int PCON_DBL    = 7;
  localparam int PCON_ERRSEL = 6;
  // serial_configuration fields
  localparam int CFG_TSEL  = 7;
  localparam int CFG_XDBL  = 6;
  localparam int CFG_URM   = 5;
  localparam int CFG_SM3   = 4;
  localparam int CFG_DOR   = 3;
  localparam int CFG_TIBLK  = 2;
  localparam int CFG_TISHR  = 1;
  localparam int CFG_ENHSEL = 0;

  // bit lengths in rate ticks, and the last count of the /3 prescale
  localparam logic [6:0] DIV_SLOW = 7'h0c;
  localparam logic [6:0] DIV_FAST = 7'h04;
  localparam logic [6:0] DIV_M2   = 7'h40;
  localparam logic [6:0] DIV_M13  = 7'h20;
  localparam logic [1:0] PRE_LAST = 2'h2;

  localparam logic [2:0] MODE_SHIFT = 3'h0;
  localparam logic [2:0] MODE_8B    = 3'h1;
  localparam logic [2:0] MODE_9BFIX = 3'h2;
  localparam logic [2:0] MODE_9BVAR = 3'h3;
  localparam logic [2:0] MODE_SPI   = 3'h4;

  typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_START, TX_DATA, TX_NINTH, TX_STOP} spc_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} spc_rx_e;
endpackage : spc_pkg
`default_nettype wire

// file: core/spc_serial_port0.sv
// spc_serial_port0: sfr registers, uart / shift / spi engines and address
// recognition of serial port 0.
// assumes: all inputs synchronous to mclk; baud overflows are 1-cycle pulses.
`default_nettype none
// Functional notes
// [RL1] mode from three bits; modes 0/4 shift
// [RL2] mode 2 rate system_clock/64..8 or /192..24; the code reaches /64../16 or /192../48
// [RL3] invalid stop sets frame error, software clears
// [RL4] control bit 7 is frame error or mode
// [RL5] frame error latched whatever the select
// [RL6] modes 2/3 filter on ninth bit, address
// [RL7] mode 1 filter on stop bit, address
// [RL8] software keeps recognition off in mode 0
// [RL9] reception only while receive enable set; mode 4 loads the buffer after each transfer regardless of enable
// [RL10] modes 2/3 send software ninth bit
// [RL11] received ninth bit: data or stop
// [RL12] transmit flag at bit 8 / stop start
// [RL13] receive flag at bit 8 / mid stop
// [RL14] one buffer: write transmits, read receives
// [RL15] given address masked by mask register
// [RL16] broadcast address is address or mask
// [RL17] address registers reset to zero
// [RL18] mask reachable only with enhanced select low
// [RL19] baud double in modes 1, 2, 3
// [RL20] timer select swaps timer 1 overflow
// [RL21] extra double when its bit is set
// [RL22] bit order: 1 lsb first, 0 msb
// [RL23] shift rate system_clock/4 or system_clock/12
// [RL24] enhanced select steers shared location
// [RL25] buffer write starts transmission
// [RL26] uart frame: start, data, ninth, stop
module spc_serial_port0 (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata_r,
  input  wire logic       rxd_in,
  output var  logic       rxd_out_r,
  output var  logic       rxd_oe_r,
  output var  logic       txd_out_r,
  input  wire logic       miso_in,
  input  wire logic       tmr1_ovf,
  input  wire logic       tmr2_ovf,
  input  wire logic       s1_brt_ovf,
  input  wire logic       tmr2_baud_sel,
  output var  logic       serial_irq_r,
  output var  logic       sysflag_ti_r
);
  import spc_pkg::*;

  logic [7:0] pcon_r, pcon_nxt, con_r, con_nxt, cfg_r, cfg_nxt;
  logic [7:0] slv_r, slv_nxt, mask_r, mask_nxt, rbuf_r, rbuf_nxt;
  logic [7:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt, rdata_nxt;
  logic       ferr_r, ferr_nxt, rx9_r, rx9_nxt, sync_rx_r, sync_rx_nxt, rxd_q_r;
  logic       txd_nxt, rxo_nxt, rxoe_nxt, irq_nxt, sysf_nxt;
  logic [6:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt, bit_len, half;
  logic [2:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt, mode;
  logic [1:0] pre_r, pre_nxt, dbl;
  spc_tx_e    tx_st_r, tx_st_nxt;
  spc_rx_e    rx_st_r, rx_st_nxt;
  logic       tick, tx_last, rx_last, sync_md, uart_md, nine, lsb1st, in_bit;
  logic       baud_ovf, hit, wr_con, wr_buf, ti_set, ri_set, ferr_set, accept;

  assign mode    = {cfg_r[CFG_SM3], con_r[CON_SM0], con_r[CON_SM1]}; // [RL1]
  assign sync_md = (mode == MODE_SHIFT) || (mode == MODE_SPI);
  assign uart_md = (mode == MODE_8B) || nine;
  assign nine    = (mode == MODE_9BFIX) || (mode == MODE_9BVAR);
  assign lsb1st  = cfg_r[CFG_DOR];
  assign dbl     = {1'b0, pcon_r[PCON_DBL]} + {1'b0, cfg_r[CFG_XDBL]}; // [RL19] [RL21]
  // sync modes count system clocks, uart modes count rate ticks
  assign bit_len = sync_md ? (cfg_r[CFG_URM] ? DIV_FAST : DIV_SLOW) // [RL23]
                 : ((mode == MODE_9BFIX ? DIV_M2 : DIV_M13) >> dbl); // [RL2]
  assign half    = bit_len >> 1;
  assign baud_ovf = tmr2_baud_sel ? tmr2_ovf : (cfg_r[CFG_TSEL] ? s1_brt_ovf : tmr1_ovf); // [RL20]
  // the /3 prescale gives the /192../48 family in mode 2
  assign tick    = sync_md || ((mode == MODE_9BFIX) ? (!cfg_r[CFG_URM] || pre_r == PRE_LAST) : baud_ovf);
  assign tx_last = tick && (tx_cnt_r == bit_len - 7'd1);
  assign rx_last = tick && (rx_cnt_r == bit_len - 7'd1);
  assign in_bit  = (mode == MODE_SPI) ? miso_in : rxd_in;
  assign hit     = (((rsh_r ^ slv_r) & mask_r) == 8'h00) // [RL15]
                || ((~rsh_r & (slv_r | mask_r)) == 8'h00); // [RL16]
  assign wr_con  = sfr_wr && (sfr_addr == ADDR_CON);
  assign wr_buf  = sfr_wr && (sfr_addr == ADDR_BUF);

  always_comb begin
    pcon_nxt = pcon_r;   con_nxt = con_r;     cfg_nxt = cfg_r;
    slv_nxt = slv_r;     mask_nxt = mask_r;   rbuf_nxt = rbuf_r;
    tsh_nxt = tsh_r;     rsh_nxt = rsh_r;     ferr_nxt = ferr_r;
    rx9_nxt = rx9_r;     sync_rx_nxt = sync_rx_r;
    tx_st_nxt = tx_st_r; tx_cnt_nxt = tx_cnt_r; tx_bit_nxt = tx_bit_r;
    rx_st_nxt = rx_st_r; rx_cnt_nxt = rx_cnt_r; rx_bit_nxt = rx_bit_r;
    ti_set = 1'b0;       ri_set = 1'b0;       ferr_set = 1'b0; accept = 1'b0;
    pre_nxt = (pre_r == PRE_LAST) ? 2'h0 : pre_r + 2'h1;
    if (tick && tx_st_r != TX_IDLE)
      tx_cnt_nxt = tx_last ? 7'h00 : tx_cnt_r + 7'h01;
    if (tick && rx_st_r != RX_IDLE)
      rx_cnt_nxt = rx_last ? 7'h00 : rx_cnt_r + 7'h01;

    case (tx_st_r)
      TX_IDLE: begin
        // mode 0 reception runs the shift clock, gated by enable and a clear flag
        if (mode == MODE_SHIFT && con_r[CON_REN] && !con_r[CON_RI]) begin // [RL9]
          tx_st_nxt = TX_SYNC;
          sync_rx_nxt = 1'b1;
          tx_cnt_nxt = 7'h00;
          tx_bit_nxt = 3'h0;
        end
      end
      TX_SYNC: begin
        if (tick && tx_cnt_r == half - 7'd1)
          rsh_nxt = lsb1st ? {in_bit, rsh_r[7:1]} : {rsh_r[6:0], in_bit}; // [RL22]
        if (tx_last) begin
          tsh_nxt = lsb1st ? {1'b0, tsh_r[7:1]} : {tsh_r[6:0], 1'b0};
          tx_bit_nxt = tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7) begin
            tx_st_nxt = TX_IDLE;
            if (sync_rx_r) begin
              ri_set = 1'b1; // [RL13]
              rbuf_nxt = rsh_nxt;
            end else begin
              ti_set = 1'b1; // [RL12]
              if (mode == MODE_SPI)
                rbuf_nxt = rsh_nxt;
            end
          end
        end
      end
      TX_START: if (tx_last) begin
        tx_st_nxt = TX_DATA;
        tx_bit_nxt = 3'h0;
      end
      TX_DATA: if (tx_last) begin
        tsh_nxt = lsb1st ? {1'b0, tsh_r[7:1]} : {tsh_r[6:0], 1'b0};
        tx_bit_nxt = tx_bit_r + 3'h1;
        if (tx_bit_r == 3'h7) begin
          tx_st_nxt = nine ? TX_NINTH : TX_STOP; // [RL26]
          ti_set = !nine; // [RL12]
        end
      end
      TX_NINTH: if (tx_last) begin
        tx_st_nxt = TX_STOP;
        ti_set = 1'b1; // [RL12]
      end
      TX_STOP: if (tx_last)
        tx_st_nxt = TX_IDLE;
      default: tx_st_nxt = TX_IDLE;
    endcase
    // a write restarts the engine even mid-byte; software paces on the flag
    if (wr_buf) begin
      tsh_nxt = sfr_wdata;
      tx_cnt_nxt = 7'h00;
      tx_bit_nxt = 3'h0;
      sync_rx_nxt = 1'b0;
      tx_st_nxt = sync_md ? TX_SYNC : (uart_md ? TX_START : TX_IDLE); // [RL25]
    end

    case (rx_st_r)
      RX_IDLE: if (uart_md && con_r[CON_REN] && rxd_q_r && !rxd_in) begin // [RL9]
        rx_st_nxt = RX_START;
        rx_cnt_nxt = half;
      end
      RX_START: if (rx_last) begin
        rx_st_nxt = rxd_in ? RX_IDLE : RX_DATA;
        rx_bit_nxt = 3'h0;
      end
      RX_DATA: if (rx_last) begin
        rsh_nxt = lsb1st ? {rxd_in, rsh_r[7:1]} : {rsh_r[6:0], rxd_in}; // [RL22]
        rx_bit_nxt = rx_bit_r + 3'h1;
        if (rx_bit_r == 3'h7)
          rx_st_nxt = nine ? RX_NINTH : RX_STOP;
      end
      RX_NINTH: if (rx_last) begin
        rx9_nxt = rxd_in;
        rx_st_nxt = RX_STOP;
      end
      RX_STOP: if (rx_last) begin
        rx_st_nxt = RX_IDLE;
        ferr_set = !rxd_in; // [RL3] [RL5]
        if (nine)
          accept = !con_r[CON_SM2] || (rx9_r && hit); // [RL6]
        else
          accept = !con_r[CON_SM2] || (rxd_in && hit); // [RL7]
        if (accept && !con_r[CON_RI]) begin
          ri_set = 1'b1; // [RL13]
          rbuf_nxt = rsh_r;
          con_nxt[CON_RB8] = nine ? rx9_r : rxd_in; // [RL11]
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (!con_r[CON_REN] || !uart_md)
      rx_st_nxt = RX_IDLE; // [RL9]

    if (wr_con) begin
      con_nxt[6:0] = sfr_wdata[6:0];
      if (pcon_r[PCON_ERRSEL])
        ferr_nxt = sfr_wdata[CON_SM0]; // [RL4]
      else
        con_nxt[CON_SM0] = sfr_wdata[CON_SM0]; // [RL4]
    end
    if (sfr_wr && sfr_addr == ADDR_PCON) pcon_nxt = sfr_wdata;
    if (sfr_wr && sfr_addr == ADDR_CFG) cfg_nxt = sfr_wdata;
    if (sfr_wr && sfr_addr == ADDR_SLV) slv_nxt = sfr_wdata;
    if (sfr_wr && sfr_addr == ADDR_MASK && !cfg_r[CFG_ENHSEL])
      mask_nxt = sfr_wdata; // [RL18] [RL24]
    // hardware set wins over a same-cycle software clear
    if (ti_set) con_nxt[CON_TI] = 1'b1;
    if (ri_set) con_nxt[CON_RI] = 1'b1;
    if (ferr_set) ferr_nxt = 1'b1; // [RL5]

    rdata_nxt = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_PCON:  rdata_nxt = pcon_r;
        ADDR_CON:   rdata_nxt = {pcon_r[PCON_ERRSEL] ? ferr_r : con_r[CON_SM0], con_r[6:0]}; // [RL4]
        ADDR_BUF:   rdata_nxt = rbuf_r; // [RL14]
        ADDR_CFG:   rdata_nxt = cfg_r;
        ADDR_SLV:   rdata_nxt = slv_r;
        ADDR_MASK:  rdata_nxt = cfg_r[CFG_ENHSEL] ? 8'h00 : mask_r; // [RL24]
        default:    rdata_nxt = 8'h00;
      endcase
    end

    // pin values follow the next state so outputs line up with the state register
    rxo_nxt = lsb1st ? tsh_nxt[0] : tsh_nxt[7];
    rxoe_nxt = (tx_st_nxt == TX_SYNC) && !sync_rx_nxt;
    case (tx_st_nxt)
      TX_SYNC:  txd_nxt = (tx_cnt_nxt >= half);
      TX_START: txd_nxt = 1'b0; // [RL26]
      TX_DATA:  txd_nxt = rxo_nxt;
      TX_NINTH: txd_nxt = con_nxt[CON_TB8]; // [RL10]
      default:  txd_nxt = 1'b1;
    endcase
    irq_nxt = con_nxt[CON_RI] || (con_nxt[CON_TI] && !cfg_nxt[CFG_TIBLK]);
    sysf_nxt = con_nxt[CON_TI] && cfg_nxt[CFG_TISHR];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pcon_r <= RST_PCON;  con_r <= RST_CON;   cfg_r <= RST_CFG; // [RL22]
      slv_r <= RST_ADDR;   mask_r <= RST_ADDR; // [RL17]
      rbuf_r <= 8'h00;     tsh_r <= 8'h00;     rsh_r <= 8'h00;
      ferr_r <= 1'b0;      rx9_r <= 1'b0;      sync_rx_r <= 1'b0;  rxd_q_r <= 1'b1;
      tx_st_r <= TX_IDLE;  tx_cnt_r <= 7'h00;  tx_bit_r <= 3'h0;
      rx_st_r <= RX_IDLE;  rx_cnt_r <= 7'h00;  rx_bit_r <= 3'h0;   pre_r <= 2'h0;
      sfr_rdata_r <= 8'h00; rxd_out_r <= 1'b0; rxd_oe_r <= 1'b0;   txd_out_r <= 1'b1;
      serial_irq_r <= 1'b0; sysflag_ti_r <= 1'b0;
    end else begin
      pcon_r <= pcon_nxt;   con_r <= con_nxt;     cfg_r <= cfg_nxt;
      slv_r <= slv_nxt;     mask_r <= mask_nxt;
      rbuf_r <= rbuf_nxt;   tsh_r <= tsh_nxt;     rsh_r <= rsh_nxt;
      ferr_r <= ferr_nxt;   rx9_r <= rx9_nxt;     sync_rx_r <= sync_rx_nxt; rxd_q_r <= rxd_in;
      tx_st_r <= tx_st_nxt; tx_cnt_r <= tx_cnt_nxt; tx_bit_r <= tx_bit_nxt;
      rx_st_r <= rx_st_nxt; rx_cnt_r <= rx_cnt_nxt; rx_bit_r <= rx_bit_nxt; pre_r <= pre_nxt;
      sfr_rdata_r <= rdata_nxt; rxd_out_r <= rxo_nxt; rxd_oe_r <= rxoe_nxt; txd_out_r <= txd_nxt;
      serial_irq_r <= irq_nxt; sysflag_ti_r <= sysf_nxt;
    end
  end

  chk_ferr_sticky: assert property (@(posedge mclk) disable iff (sys_rst) // [RL3]
    ferr_r && !wr_con |=> ferr_r) else $error("frame error flag lost");
  chk_ferr_any_select: assert property (@(posedge mclk) disable iff (sys_rst) // [RL5]
    rx_st_r == RX_STOP && rx_last && !rxd_in |=> ferr_r) else $error("frame error not latched");
  chk_addr_filter: assert property (@(posedge mclk) disable iff (sys_rst) // [RL6]
    ri_set && nine && con_r[CON_SM2] |-> rx9_r && hit) else $error("address filter passed bad frame");
  chk_addr_reset: assert property (@(posedge mclk) // [RL17]
    $fell(sys_rst) |-> slv_r == 8'h00 && mask_r == 8'h00) else $error("address registers not cleared");
  chk_ren_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [RL9]
    !con_r[CON_REN] |=> rx_st_r == RX_IDLE) else $error("reception while disabled");
  chk_tx_start: assert property (@(posedge mclk) disable iff (sys_rst) // [RL25]
    wr_buf && uart_md |=> tx_st_r == TX_START ##1 !txd_out_r) else $error("write did not start frame");
  chk_ninth_out: assert property (@(posedge mclk) disable iff (sys_rst) // [RL10]
    tx_st_r == TX_NINTH |-> txd_out_r == con_r[CON_TB8]) else $error("ninth bit wrong on line");
  chk_mode2_rate: assert property (@(posedge mclk) disable iff (sys_rst) // [RL2]
    mode == MODE_9BFIX && dbl == 2'h0 |-> bit_len == 7'h40) else $error("mode 2 rate wrong");
  chk_shift_rate: assert property (@(posedge mclk) disable iff (sys_rst) // [RL23]
    sync_md && !cfg_r[CFG_URM] |-> bit_len == 7'h0c) else $error("shift rate wrong");
  chk_ti_stop: assert property (@(posedge mclk) disable iff (sys_rst) // [RL12]
    uart_md && $rose(tx_st_r == TX_STOP) && !wr_buf |-> con_r[CON_TI]) else $error("transmit flag late");
endmodule // spc_serial_port0
`default_nettype wire

// file: dv/spc_remote_node.sv
// spc_remote_node: far uart node that drives the port's receive line.
// assumes: bit length is given in mclk cycles; the line idles high as if pulled up.
`default_nettype none
module spc_remote_node (
  input  wire logic mclk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b1;
  // start low, eight data bits, ninth bit, stop; a bad stop is sent only on request
  task automatic send(input logic [7:0] b, input logic nb, input logic stop, input int blen, input logic lsb);
    logic [10:0] f;
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) f[k+1] = lsb ? b[k] : b[7-k];
    f[9] = nb;
    f[10] = stop;
    for (int k = 0; k < 11; k++) begin
      line = f[k];
      repeat (blen) @(negedge mclk);
    end
    line = 1'b1;
  endtask
endmodule // spc_remote_node
`default_nettype wire

// file: dv/serial_port0_control_test.sv
// serial_port0_control_test: self-checking bench for serial port 0 in mode 2.
// assumes: spc_pkg constants; 10 MHz mclk; timer overflow inputs unused in mode 2.
`default_nettype none
module serial_port0_control_test;
  import spc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, sfr_wr, sfr_rd, miso_in;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_r, v, sa, sm, b;
  logic        rxd_in, rxd_out_r, rxd_oe_r, txd_out_r, serial_irq_r, sysflag_ti_r, nb, exp_ri;
  logic [8:0]  got;
  logic [31:0] seed = 32'h84ec;
  logic [7:0]  regs[6] = '{ADDR_PCON, ADDR_CON, ADDR_CFG, ADDR_SLV, ADDR_MASK, 8'h9d};
  logic [7:0]  rsts[6] = '{RST_PCON, RST_CON, RST_CFG, RST_ADDR, RST_ADDR, 8'h00};
  int          miscompares = 0;
  int          n_compared = 0;

  spc_serial_port0 DUT (.mclk(mclk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .rxd_in(rxd_in),
    .rxd_out_r(rxd_out_r), .rxd_oe_r(rxd_oe_r), .txd_out_r(txd_out_r), .miso_in(miso_in),
    .tmr1_ovf(1'b0), .tmr2_ovf(1'b0), .s1_brt_ovf(1'b0), .tmr2_baud_sel(1'b0),
    .serial_irq_r(serial_irq_r), .sysflag_ti_r(sysflag_ti_r));
  spc_remote_node peer (.mclk(mclk), .line(rxd_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(negedge mclk) miso_in <= seed[3];

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int k = 0; k < 8; k++) rev[k] = x[7-k];
  endfunction
  function automatic logic hit(input logic [7:0] x, input logic [7:0] a, input logic [7:0] m);
    return (((x ^ a) & m) == 8'h00) || ((~x & (a | m)) == 8'h00);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // each bus task starts and ends on a falling edge, so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    d = sfr_rdata_r;
    @(negedge mclk);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    foreach (regs[i]) begin
      rd(regs[i], v);
      check("reset value", v, rsts[i]);
    end
    $display("test reset done");
    wr(ADDR_CFG, 8'h09);
    wr(ADDR_MASK, 8'hff);
    rd(ADDR_MASK, v);
    check("mask hidden", v, 8'h00);
    wr(ADDR_CFG, 8'h08);
    rd(ADDR_MASK, v);
    check("mask write ignored", v, 8'h00);
    $display("test mask access done");
    // mode 2 with both doublings: 64 >> 2 gives 16 clocks per bit
    wr(ADDR_PCON, 8'h80);
    for (int i = 0; i < 4; i++) begin
      b = rnd();
      nb = i[1] ^ seed[7];
      wr(ADDR_CFG, {4'h4, i[0], 3'h0});
      wr(ADDR_CON, {4'h8, nb, 3'h0});
      wr(ADDR_BUF, b);
      for (int k = 0; k < 8 && txd_out_r; k++) @(negedge mclk);
      repeat (8) @(negedge mclk);
      check("start bit", {7'h0, txd_out_r}, 8'h00);
      for (int k = 0; k < 9; k++) begin
        repeat (16) @(negedge mclk);
        got[k] = txd_out_r;
      end
      check("data bits", got[7:0], i[0] ? b : rev(b));
      check("ninth bit", {7'h0, got[8]}, {7'h0, nb});
      rd(ADDR_CON, v);
      check("tx flag early", {7'h0, v[CON_TI]}, 8'h00);
      // ninth bit still stands for 4 more clocks, then 16 of stop; land 2 clocks past the stop bit
      repeat (22) @(negedge mclk);
      check("stop bit", {7'h0, txd_out_r}, 8'h01);
      rd(ADDR_CON, v);
      check("tx flag", {7'h0, v[CON_TI]}, 8'h01);
      check("serial irq", {7'h0, serial_irq_r}, 8'h01);
      check("shared vector", {7'h0, sysflag_ti_r}, 8'h00);
      check("rxd not driven", {6'h0, rxd_oe_r, 1'b0}, 8'h00);
    end
    $display("test transmit done");
    sa = rnd();
    sm = rnd();
    wr(ADDR_CFG, 8'h48);
    wr(ADDR_SLV, sa);
    wr(ADDR_MASK, sm);
    for (int i = 0; i < 8; i++) begin
      b = i[1] ? sa : rnd();
      nb = i[0] | seed[9];
      wr(ADDR_CON, {2'h2, i[2], 5'h10});  // recognition only in mode 2, never mode 0
      peer.send(b, nb, 1'b1, 16, 1'b1);
      rd(ADDR_CON, v);
      exp_ri = !i[2] || (nb && hit(b, sa, sm));
      check("rx flag", {7'h0, v[CON_RI]}, {7'h0, exp_ri});
      if (exp_ri) begin
        check("ninth in", {7'h0, v[CON_RB8]}, {7'h0, nb});
        rd(ADDR_BUF, v);
        check("rx byte", v, b);
      end
    end
    wr(ADDR_CON, 8'h80);
    peer.send(8'h3c, 1'b1, 1'b1, 16, 1'b1);
    rd(ADDR_CON, v);
    check("rx disabled", {7'h0, v[CON_RI]}, 8'h00);
    $display("test receive done");
    wr(ADDR_CON, 8'h90);
    wr(ADDR_PCON, 8'hc0);
    rd(ADDR_CON, v);
    check("shared bit", {7'h0, v[7]}, 8'h00);
    wr(ADDR_PCON, 8'h80);
    peer.send(8'ha5, 1'b0, 1'b0, 16, 1'b1);
    wr(ADDR_PCON, 8'hc0);
    rd(ADDR_CON, v);
    check("frame error", {7'h0, v[7]}, 8'h01);
    wr(ADDR_CON, 8'h90);
    peer.send(8'h5a, 1'b0, 1'b1, 16, 1'b1);
    rd(ADDR_CON, v);
    check("frame error kept", {7'h0, v[7]}, 8'h01);
    wr(ADDR_CON, 8'h10);
    rd(ADDR_CON, v);
    check("frame error cleared", {7'h0, v[7]}, 8'h00);
    $display("test framing done");
    summarize();
  end
endmodule // serial_port0_control_test
`default_nettype wire
